/* File: core/vco_autocal.sv */
/*
  VCO band calibration sequencer with register file, readback selector and
  temperature converter control, all on the comparison clock.
  Assumes the serial port logic presents one-cycle write and read strobes with
  a 12-bit address, and that the comparator of the band search and the raw
  temperature code arrive as synchronous inputs.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Writing N integer low starts calibration.
// - Selector bits 7:5 choose readback quantity.
// - Selector 1 shows band and core one; the band readback holds only bits 4:0 of the band.
// - Cleared enable bit blocks calibration start.
// - Override mode 010 uses manual core, band.
// - In override mode, oscillator enabled only when core selected; otherwise always enabled.
// - Manual mode applies manual band register.
// - Integer low write is last, triggers lock.
// - Settle lasts coarse times 1024 plus fine.
// - Coarse and fine timeout field placement.
// - Band clock is comparison clock divided.
// - Band search: eleven steps, sixteen clocks.
// - Converter clock divides by div*4+2.
// - Conversion completes only with reference clock.
// - Enable, convert and clock gate bits.
// - Temperature equals raw code minus 100; the readback returns the latched raw code with no offset subtracted.
// - Lock status bit 0 shows lock.
module vco_autocal (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  // Register port.
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  // Analog side.
  input  wire logic        i_band_cmp_high,
  input  wire logic        i_lock_detect,
  input  wire logic [7:0]  i_raw_temp,
  output logic [7:0]       o_vco_band,
  output logic             o_vco_enable,
  output logic             o_cal_busy,
  output logic             o_adc_clk
);

  // Register storage.
  logic [7:0] n_int_low_ff, cal_enable_ff, band_div_ff, fine_low_ff;
  logic [7:0] fine_high_adc_ff, rb_sel_coarse_ff, test_mode_ff, adc_div_ff;
  logic [7:0] manual_band_ff, manual_core_ff, adc_gate_ff;
  logic [7:0] nxt_n_int_low, nxt_cal_enable, nxt_band_div, nxt_fine_low;
  logic [7:0] nxt_fine_high_adc, nxt_rb_sel_coarse, nxt_test_mode, nxt_adc_div;
  logic [7:0] nxt_manual_band, nxt_manual_core, nxt_adc_gate;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       start_req;

  // Register writes; the integer write also raises the start request.
  always_comb begin
    nxt_n_int_low     = n_int_low_ff;
    nxt_cal_enable    = cal_enable_ff;
    nxt_band_div      = band_div_ff;
    nxt_fine_low      = fine_low_ff;
    nxt_fine_high_adc = fine_high_adc_ff;
    nxt_rb_sel_coarse = rb_sel_coarse_ff;
    nxt_test_mode     = test_mode_ff;
    nxt_adc_div       = adc_div_ff;
    nxt_manual_band   = manual_band_ff;
    nxt_manual_core   = manual_core_ff;
    nxt_adc_gate      = adc_gate_ff;
    start_req         = 1'b0;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        vco_cal_pkg::ADDR_N_INT_LOW: begin
          nxt_n_int_low = i_reg_wdata;
          start_req     = 1'b1;
        end
        vco_cal_pkg::ADDR_CAL_ENABLE:    nxt_cal_enable    = i_reg_wdata;
        vco_cal_pkg::ADDR_BAND_DIV:      nxt_band_div      = i_reg_wdata;
        vco_cal_pkg::ADDR_FINE_LOW:      nxt_fine_low      = i_reg_wdata;
        vco_cal_pkg::ADDR_FINE_HIGH_ADC: nxt_fine_high_adc = i_reg_wdata;
        vco_cal_pkg::ADDR_RB_SEL_COARSE: nxt_rb_sel_coarse = i_reg_wdata;
        vco_cal_pkg::ADDR_CAL_TEST_MODE: nxt_test_mode     = i_reg_wdata;
        vco_cal_pkg::ADDR_ADC_DIV:       nxt_adc_div       = i_reg_wdata;
        vco_cal_pkg::ADDR_MANUAL_BAND:   nxt_manual_band   = i_reg_wdata;
        vco_cal_pkg::ADDR_MANUAL_CORE:   nxt_manual_core   = i_reg_wdata;
        vco_cal_pkg::ADDR_ADC_CLK_GATE:  nxt_adc_gate      = i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      n_int_low_ff     <= vco_cal_pkg::RST_ZERO;
      cal_enable_ff    <= vco_cal_pkg::RST_CAL_ENABLE;
      band_div_ff      <= vco_cal_pkg::RST_BAND_DIV;
      fine_low_ff      <= vco_cal_pkg::RST_FINE_LOW;
      fine_high_adc_ff <= vco_cal_pkg::RST_ZERO;
      rb_sel_coarse_ff <= vco_cal_pkg::RST_COARSE;
      test_mode_ff     <= vco_cal_pkg::RST_ZERO;
      adc_div_ff       <= vco_cal_pkg::RST_ADC_DIV;
      manual_band_ff   <= vco_cal_pkg::RST_ZERO;
      manual_core_ff   <= vco_cal_pkg::RST_ZERO;
      adc_gate_ff      <= vco_cal_pkg::RST_ZERO;
    end else begin
      n_int_low_ff     <= nxt_n_int_low;
      cal_enable_ff    <= nxt_cal_enable;
      band_div_ff      <= nxt_band_div;
      fine_low_ff      <= nxt_fine_low;
      fine_high_adc_ff <= nxt_fine_high_adc;
      rb_sel_coarse_ff <= nxt_rb_sel_coarse;
      test_mode_ff     <= nxt_test_mode;
      adc_div_ff       <= nxt_adc_div;
      manual_band_ff   <= nxt_manual_band;
      manual_core_ff   <= nxt_manual_core;
      adc_gate_ff      <= nxt_adc_gate;
    end
  end

  // Decoded fields.
  logic       auto_cal_enable;
  logic       manual_mode;
  logic       core_selected;
  logic [4:0] coarse_settle_count;
  logic [9:0] fine_settle_count;
  logic [2:0] readback_selector;
  assign auto_cal_enable     = cal_enable_ff[vco_cal_pkg::AUTO_CAL_EN_BIT];
  assign manual_mode         = (test_mode_ff[vco_cal_pkg::OVERRIDE_LSB +: 3] == vco_cal_pkg::OVERRIDE_MANUAL);
  assign core_selected       = (manual_core_ff[vco_cal_pkg::CORE_SEL_LSB +: 4] == vco_cal_pkg::CORE_SEL_ONE);
  assign coarse_settle_count = rb_sel_coarse_ff[4:0];
  assign fine_settle_count   = {fine_high_adc_ff[1:0], fine_low_ff};
  assign readback_selector   = rb_sel_coarse_ff[vco_cal_pkg::RB_SEL_LSB +: 3];

  // Settling length in comparison clocks.
  logic [15:0] settle_len;
  assign settle_len = 16'({coarse_settle_count, 10'd0}) + 16'(fine_settle_count);

  // Band clock divider runs only while searching.
  logic band_tick;
  vco_cal_pkg::cal_state_t state_ff, nxt_state;
  clk_pulse_div #(.W(8)) u_band_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (state_ff == vco_cal_pkg::CAL_BAND),
    .i_div     (band_div_ff),
    .o_tick    (band_tick)
  );

  // Calibration sequencer state.
  logic [15:0] settle_ff, nxt_settle;
  logic [3:0]  sub_ff, nxt_sub;
  logic [3:0]  step_ff, nxt_step;
  logic [7:0]  band_ff, nxt_band;
  logic [7:0]  found_band_ff, nxt_found_band;
  logic        busy_ff, nxt_busy;
  logic        vco_en_ff, nxt_vco_en;

  // Sequencer: settle, then a binary band search, one trial bit per step for the first eight steps.
  always_comb begin
    nxt_state      = state_ff;
    nxt_settle     = settle_ff;
    nxt_sub        = sub_ff;
    nxt_step       = step_ff;
    nxt_band       = band_ff;
    nxt_found_band = found_band_ff;
    if (start_req && auto_cal_enable && !manual_mode) begin
      nxt_state  = vco_cal_pkg::CAL_SETTLE;
      nxt_settle = '0;
      nxt_sub    = '0;
      nxt_step   = '0;
      nxt_band   = 8'h80;
    end else begin
      unique case (state_ff)
        vco_cal_pkg::CAL_IDLE: ;
        vco_cal_pkg::CAL_SETTLE: begin
          if ((settle_ff + 16'd1) >= settle_len) begin
            nxt_state = vco_cal_pkg::CAL_BAND;
          end else begin
            nxt_settle = settle_ff + 16'd1;
          end
        end
        vco_cal_pkg::CAL_BAND: begin
          if (band_tick) begin
            nxt_sub = sub_ff + 4'd1;
            if (sub_ff == 4'(vco_cal_pkg::STEP_CLOCKS - 1)) begin
              // Keep or drop the trial bit, then try the next lower one.
              if (step_ff < 4'd8) begin
                nxt_band = i_band_cmp_high ? band_ff : (band_ff & ~(8'h80 >> step_ff));
                if (step_ff < 4'd7) begin
                  nxt_band = nxt_band | (8'h40 >> step_ff);
                end
              end
              nxt_step = step_ff + 4'd1;
              if (step_ff == 4'(vco_cal_pkg::BAND_STEPS - 1)) begin
                nxt_state      = vco_cal_pkg::CAL_DONE;
                nxt_found_band = nxt_band;
              end
            end
          end
        end
        vco_cal_pkg::CAL_DONE: nxt_state = vco_cal_pkg::CAL_IDLE;
      endcase
    end
    nxt_busy   = (nxt_state == vco_cal_pkg::CAL_SETTLE) || (nxt_state == vco_cal_pkg::CAL_BAND);
    nxt_vco_en = manual_mode ? core_selected : 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff      <= vco_cal_pkg::CAL_IDLE;
      settle_ff     <= '0;
      sub_ff        <= '0;
      step_ff       <= '0;
      band_ff       <= '0;
      found_band_ff <= '0;
      busy_ff       <= 1'b0;
      vco_en_ff     <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      settle_ff     <= nxt_settle;
      sub_ff        <= nxt_sub;
      step_ff       <= nxt_step;
      band_ff       <= nxt_band;
      found_band_ff <= nxt_found_band;
      busy_ff       <= nxt_busy;
      vco_en_ff     <= nxt_vco_en;
    end
  end

  // Applied band: manual value in override mode, else the searched one.
  logic [7:0] vco_band_ff, nxt_vco_band;
  always_comb begin
    nxt_vco_band = manual_mode ? manual_band_ff : (busy_ff ? band_ff : found_band_ff);
  end

  // Converter clock: toggle every div*2+1 cycles gives div*4+2 per period.
  logic       adc_run;
  logic       adc_half_tick;
  logic [9:0] adc_half_div;
  logic       adc_clk_ff, nxt_adc_clk;
  logic       adc_tick;
  logic [7:0] temp_result;
  assign adc_run      = fine_high_adc_ff[vco_cal_pkg::ADC_ENABLE_BIT] &&
                        !adc_gate_ff[vco_cal_pkg::ADC_CLK_OFF_BIT];
  assign adc_half_div = {1'b0, adc_div_ff, 1'b0} + 10'd1;
  assign adc_tick     = adc_half_tick && adc_clk_ff;

  clk_pulse_div #(.W(10)) u_adc_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (adc_run),
    .i_div     (adc_half_div),
    .o_tick    (adc_half_tick)
  );

  always_comb begin
    nxt_adc_clk = adc_run ? (adc_clk_ff ^ adc_half_tick) : 1'b0;
  end

  temp_adc_ctrl u_temp (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_enable   (fine_high_adc_ff[vco_cal_pkg::ADC_ENABLE_BIT]),
    .i_convert  (fine_high_adc_ff[vco_cal_pkg::ADC_CONVERT_BIT]),
    .i_adc_tick (adc_tick),
    .i_raw_temp (i_raw_temp),
    .o_result   (temp_result),
    .o_done     ()
  );

  // Read mux; readback data follows the selector, unmapped reads return zero.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        vco_cal_pkg::ADDR_N_INT_LOW:     nxt_rdata = n_int_low_ff;
        vco_cal_pkg::ADDR_CAL_ENABLE:    nxt_rdata = cal_enable_ff;
        vco_cal_pkg::ADDR_BAND_DIV:      nxt_rdata = band_div_ff;
        vco_cal_pkg::ADDR_FINE_LOW:      nxt_rdata = fine_low_ff;
        vco_cal_pkg::ADDR_FINE_HIGH_ADC: nxt_rdata = fine_high_adc_ff;
        vco_cal_pkg::ADDR_RB_SEL_COARSE: nxt_rdata = rb_sel_coarse_ff;
        vco_cal_pkg::ADDR_CAL_TEST_MODE: nxt_rdata = test_mode_ff;
        vco_cal_pkg::ADDR_ADC_DIV:       nxt_rdata = adc_div_ff;
        vco_cal_pkg::ADDR_MANUAL_BAND:   nxt_rdata = manual_band_ff;
        vco_cal_pkg::ADDR_MANUAL_CORE:   nxt_rdata = manual_core_ff;
        vco_cal_pkg::ADDR_ADC_CLK_GATE:  nxt_rdata = adc_gate_ff;
        vco_cal_pkg::ADDR_RB_DATA_LOW: begin
          if (readback_selector == vco_cal_pkg::RB_SEL_BAND_CORE) begin
            nxt_rdata = {3'd0, vco_band_ff[4:0]};
          end else if (readback_selector == vco_cal_pkg::RB_SEL_TEMP) begin
            nxt_rdata = temp_result;
          end else begin
            nxt_rdata = 8'h00;
          end
        end
        vco_cal_pkg::ADDR_RB_CORE:
          nxt_rdata = {7'd0, readback_selector == vco_cal_pkg::RB_SEL_BAND_CORE};
        vco_cal_pkg::ADDR_LOCK_STATUS:
          nxt_rdata = {7'd0, i_lock_detect};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_ff    <= '0;
      vco_band_ff <= '0;
      adc_clk_ff  <= 1'b0;
    end else begin
      rdata_ff    <= nxt_rdata;
      vco_band_ff <= nxt_vco_band;
      adc_clk_ff  <= nxt_adc_clk;
    end
  end

  assign o_reg_rdata  = rdata_ff;
  assign o_vco_band   = vco_band_ff;
  assign o_vco_enable = vco_en_ff;
  assign o_cal_busy   = busy_ff;
  assign o_adc_clk    = adc_clk_ff;

  // Checks.
  sequence s_start;
    i_reg_wr && i_reg_addr == vco_cal_pkg::ADDR_N_INT_LOW && auto_cal_enable && !manual_mode;
  endsequence

  a_start_cal: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    s_start |=> state_ff == vco_cal_pkg::CAL_SETTLE && settle_ff == 16'd0)
    else $error("integer write did not start calibration");
  a_start_blocked: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (state_ff == vco_cal_pkg::CAL_IDLE && i_reg_wr && !auto_cal_enable) |=> state_ff == vco_cal_pkg::CAL_IDLE)
    else $error("calibration started while disabled");
  a_settle_length: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_ff == vco_cal_pkg::CAL_BAND && $past(state_ff) == vco_cal_pkg::CAL_SETTLE
      |-> $past(settle_ff) + 16'd1 >= $past(settle_len))
    else $error("settle phase ended early");
  a_step_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    state_ff == vco_cal_pkg::CAL_BAND |-> step_ff < 4'(vco_cal_pkg::BAND_STEPS))
    else $error("band search step count exceeded");
  a_manual_band: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    manual_mode && $stable(manual_band_ff) && $past(manual_mode) |=> vco_band_ff == $past(manual_band_ff))
    else $error("manual band not applied");
  a_core_enable: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    manual_mode && !core_selected |=> !o_vco_enable)
    else $error("oscillator enabled without core");
  a_core_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_reg_rd && i_reg_addr == vco_cal_pkg::ADDR_RB_CORE && readback_selector == vco_cal_pkg::RB_SEL_BAND_CORE
      |=> o_reg_rdata == 8'h01)
    else $error("core readback not one");
  a_lock_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_reg_rd && i_reg_addr == vco_cal_pkg::ADDR_LOCK_STATUS |=> o_reg_rdata[0] == $past(i_lock_detect))
    else $error("lock bit readback wrong");
  a_adc_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    adc_gate_ff[vco_cal_pkg::ADC_CLK_OFF_BIT] ##1 adc_gate_ff[vco_cal_pkg::ADC_CLK_OFF_BIT] |-> !o_adc_clk)
    else $error("converter clock runs while gated");

endmodule // vco_autocal
`default_nettype wire

/* File: core/vco_cal_pkg.sv */
/*
  Shared constants for the VCO band calibration and temperature readback block.
  Assumes a register port of 12-bit addresses and 8-bit data from the serial port logic.
*/
package vco_cal_pkg;

  // Register offsets.
  localparam logic [11:0] ADDR_N_INT_LOW      = 12'h0010;
  localparam logic [11:0] ADDR_CAL_ENABLE     = 12'h0012;
  localparam logic [11:0] ADDR_BAND_DIV       = 12'h0030;
  localparam logic [11:0] ADDR_FINE_LOW       = 12'h0031;
  localparam logic [11:0] ADDR_FINE_HIGH_ADC  = 12'h0032;
  localparam logic [11:0] ADDR_RB_SEL_COARSE  = 12'h0033;
  localparam logic [11:0] ADDR_CAL_TEST_MODE  = 12'h0034;
  localparam logic [11:0] ADDR_ADC_DIV        = 12'h0035;
  localparam logic [11:0] ADDR_MANUAL_BAND    = 12'h0037;
  localparam logic [11:0] ADDR_MANUAL_CORE    = 12'h0038;
  localparam logic [11:0] ADDR_RB_DATA_LOW    = 12'h006e;
  localparam logic [11:0] ADDR_RB_CORE        = 12'h006f;
  localparam logic [11:0] ADDR_ADC_CLK_GATE   = 12'h0073;
  localparam logic [11:0] ADDR_LOCK_STATUS    = 12'h007c;

  // Field positions.
  localparam int AUTO_CAL_EN_BIT  = 6;
  localparam int ADC_ENABLE_BIT   = 2;
  localparam int ADC_CONVERT_BIT  = 3;
  localparam int ADC_CLK_OFF_BIT  = 2;
  localparam int RB_SEL_LSB       = 5;
  localparam int OVERRIDE_LSB     = 5;
  localparam int CORE_SEL_LSB     = 4;

  // Field codes.
  localparam logic [2:0] RB_SEL_BAND_CORE = 3'h1;
  localparam logic [2:0] RB_SEL_TEMP      = 3'h5;
  localparam logic [2:0] OVERRIDE_MANUAL  = 3'h2;
  localparam logic [3:0] CORE_SEL_ONE     = 4'h1;

  // Reset values.
  localparam logic [7:0] RST_CAL_ENABLE = 8'h40;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_BAND_DIV   = 8'h19;
  localparam logic [7:0] RST_FINE_LOW   = 8'h02;
  localparam logic [7:0] RST_COARSE     = 8'h02;
  localparam logic [7:0] RST_ADC_DIV    = 8'hff;

  // Timing constants and the temperature offset.
  localparam int SETTLE_COARSE_SCALE = 1024;
  localparam int BAND_STEPS          = 11;
  localparam int STEP_CLOCKS         = 16;
  localparam int ADC_CONV_CLOCKS     = 16;
  localparam int TEMP_OFFSET_C       = 100;

  typedef enum {
    CAL_IDLE,
    CAL_SETTLE,
    CAL_BAND,
    CAL_DONE
  } cal_state_t;

endpackage

/* File: core/clk_pulse_div.sv */
/*
  Divides the system clock into a one-cycle tick every divisor cycles.
  Assumes the divisor is held steady while the divider runs.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_pulse_div #(
  parameter int W = 10
) (
  // Clock and reset.
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  // Control.
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_div,
  // Tick.
  output logic              o_tick
);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic         tick_ff;
  logic         nxt_tick;

  // Count up to the divisor minus one; a zero divisor acts as one.
  always_comb begin
    nxt_count = '0;
    nxt_tick  = 1'b0;
    if (i_run) begin
      if ((count_ff + W'(1)) >= i_div) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_count = count_ff + W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff  <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

  a_tick_gated: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !i_run |=> !o_tick)
    else $error("divider ticked while stopped");

endmodule // clk_pulse_div
`default_nettype wire

/* File: core/temp_adc_ctrl.sv */
/*
  Conversion control for the temperature converter: counts converter clocks
  after a request and latches the raw result.
  Assumes the converter tick comes from a divider of the comparison clock.
*/
`timescale 1ns/1ps
`default_nettype none
module temp_adc_ctrl (
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  // Control.
  input  wire logic       i_enable,
  input  wire logic       i_convert,
  input  wire logic       i_adc_tick,
  input  wire logic [7:0] i_raw_temp,
  // Result.
  output logic [7:0]      o_result,
  output logic            o_done
);

  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [7:0] result_ff;
  logic [7:0] nxt_result;
  logic       done_ff;
  logic       nxt_done;

  // A conversion needs sixteen converter clocks; without ticks it never ends.
  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_result = result_ff;
    nxt_done   = done_ff;
    if (!i_enable || !i_convert) begin
      nxt_cnt  = '0;
      nxt_done = 1'b0;
    end else if (i_adc_tick && !done_ff) begin
      if (cnt_ff == 5'(vco_cal_pkg::ADC_CONV_CLOCKS - 1)) begin
        nxt_done   = 1'b1;
        nxt_result = i_raw_temp;
      end else begin
        nxt_cnt = cnt_ff + 5'd1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff    <= '0;
      result_ff <= '0;
      done_ff   <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      result_ff <= nxt_result;
      done_ff   <= nxt_done;
    end
  end

  assign o_result = result_ff;
  assign o_done   = done_ff;

  a_done_needs_conv: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_done |-> $past(i_enable) && $past(i_convert))
    else $error("conversion done without request");

endmodule // temp_adc_ctrl
`default_nettype wire

/* File: test/vco_analog_model.sv */
/*
  Behavioural model of the oscillator side: band comparator and lock detector.
  Assumes the band search keeps a trial bit while the comparator is high.
*/
`timescale 1ns/1ps
`default_nettype none
module vco_analog_model #(
  parameter logic [7:0] TARGET_BAND = 8'h13
) (
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_b,
  // Oscillator control.
  input  wire logic [7:0] i_vco_band,
  input  wire logic       i_cal_busy,
  input  wire logic       i_vco_enable,
  // Analog answers.
  output logic            o_band_cmp_high,
  output logic            o_lock_detect
);
  // The trial band is still at or below the band that tunes to the target.
  assign o_band_cmp_high = (i_vco_band <= TARGET_BAND);

  // Lock is declared one cycle after the search ends and drops one cycle after a search starts.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lock_detect <= 1'b0;
    end else begin
      o_lock_detect <= i_vco_enable & ~i_cal_busy;
    end
  end
endmodule // vco_analog_model
`default_nettype wire

/* File: test/vco_autocal_tb_top.sv */
/*
  Self-checking bench for the calibration and temperature readback block.
  Assumes one 10 MHz clock; the bench plays the serial host on the register port.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module vco_autocal_tb_top;
  localparam logic [7:0] TGT = 8'h13;
  typedef struct { logic wr; logic [11:0] a; logic [7:0] d; logic [7:0] e; } row_t;
  logic       i_sys_clk = 1'b0, i_rst_b = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [11:0] i_reg_addr = 12'h0000;
  logic [7:0] i_reg_wdata = 8'h00, i_raw_temp = 8'h7d, o_reg_rdata, o_vco_band;
  logic       i_band_cmp_high, i_lock_detect, o_vco_enable, o_cal_busy, o_adc_clk, prev;
  int         fail_count = 0, total_checks = 0, n;
  row_t       rows [9] = '{'{1'b0, 12'h0012, 8'h00, 8'h40}, '{1'b0, 12'h0030, 8'h00, 8'h19},
    '{1'b0, 12'h0031, 8'h00, 8'h02}, '{1'b0, 12'h0033, 8'h00, 8'h02}, '{1'b0, 12'h0035, 8'h00, 8'hff},
    '{1'b0, 12'h0037, 8'h00, 8'h00}, '{1'b0, 12'h00ff, 8'h00, 8'h00}, '{1'b1, 12'h006f, 8'h55, 8'h00},
    '{1'b1, 12'h0030, 8'h03, 8'h03}};

  // Design under test with the oscillator model on its analog side.
  vco_autocal vco_autocal_inst (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_band_cmp_high(i_band_cmp_high), .i_lock_detect(i_lock_detect),
    .i_raw_temp(i_raw_temp), .o_vco_band(o_vco_band), .o_vco_enable(o_vco_enable),
    .o_cal_busy(o_cal_busy), .o_adc_clk(o_adc_clk));
  vco_analog_model #(.TARGET_BAND(TGT)) vco_analog_model_inst (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_vco_band(o_vco_band), .i_cal_busy(o_cal_busy),
    .i_vco_enable(o_vco_enable), .o_band_cmp_high(i_band_cmp_high), .o_lock_detect(i_lock_detect));

  // Free-running 10 MHz clock.
  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // Strobes are one cycle wide and change only at falling edges.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge i_sys_clk) {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
    @(negedge i_sys_clk) i_reg_wr = 1'b0;
  endtask
  // Read data lands one edge after the read edge, so one more cycle is spent.
  task automatic rd(input logic [11:0] a);
    @(negedge i_sys_clk) {i_reg_rd, i_reg_addr} = {1'b1, a};
    @(negedge i_sys_clk) i_reg_rd = 1'b0;
    @(negedge i_sys_clk);
  endtask
  // Counts converter clock rising edges over a number of cycles.
  task automatic rises(input int cyc);
    n = 0;
    prev = o_adc_clk;
    repeat (cyc) begin
      @(negedge i_sys_clk);
      if (o_adc_clk === 1'b1 && prev !== 1'b1) n++;
      prev = o_adc_clk;
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence: table of register cases, then the hand-written scenarios.
  initial begin
    repeat (20) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK(o_reg_rdata, rows[i].e)
    end
    // Settle is 2*1024+2 cycles, band search 11*16 ticks of divider 3, which keeps the band clock under 4 MHz.
    wr(vco_cal_pkg::ADDR_N_INT_LOW, 8'h20);
    @(negedge i_sys_clk);
    `CHK(o_cal_busy, 1'b1)
    repeat (1000) @(negedge i_sys_clk);
    wr(vco_cal_pkg::ADDR_N_INT_LOW, 8'h20);
    repeat (2040) @(negedge i_sys_clk);
    `CHK(o_cal_busy, 1'b1)
    n = 0;
    while (o_cal_busy === 1'b1 && n < 600) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= 600) begin
      fail_count++;
      stop_test();
    end
    `CHK(o_vco_band, TGT)
    wr(vco_cal_pkg::ADDR_RB_SEL_COARSE, 8'h22);
    rd(vco_cal_pkg::ADDR_RB_DATA_LOW);
    `CHK(o_reg_rdata[4:0], TGT[4:0])
    rd(vco_cal_pkg::ADDR_RB_CORE);
    `CHK(o_reg_rdata[0], 1'b1)
    rd(vco_cal_pkg::ADDR_LOCK_STATUS);
    `CHK(o_reg_rdata[0], 1'b1)
    // A start with the enable bit clear must be ignored.
    wr(vco_cal_pkg::ADDR_CAL_ENABLE, 8'h00);
    wr(vco_cal_pkg::ADDR_N_INT_LOW, 8'h21);
    `CHK(o_cal_busy, 1'b0)
    // Manual override applies the written core and band, and refuses a start even when enabled.
    wr(vco_cal_pkg::ADDR_CAL_TEST_MODE, 8'h40);
    wr(vco_cal_pkg::ADDR_CAL_ENABLE, 8'h40);
    wr(vco_cal_pkg::ADDR_MANUAL_CORE, 8'h10);
    wr(vco_cal_pkg::ADDR_MANUAL_BAND, 8'ha5);
    wr(vco_cal_pkg::ADDR_N_INT_LOW, 8'h22);
    `CHK(o_cal_busy, 1'b0)
    `CHK(o_vco_band, 8'ha5)
    `CHK(o_vco_enable, 1'b1)
    wr(vco_cal_pkg::ADDR_MANUAL_CORE, 8'h00);
    @(negedge i_sys_clk);
    `CHK(o_vco_enable, 1'b0)
    // Converter divider 1 gives a period of 1*4+2 = 6 cycles, so 60 cycles hold ten rises.
    wr(vco_cal_pkg::ADDR_ADC_DIV, 8'h01);
    wr(vco_cal_pkg::ADDR_FINE_HIGH_ADC, 8'h04);
    rises(60);
    `CHK(n, 10)
    // Divider 25 puts the converter near 100 kHz; sixteen periods of 102 cycles fit in the wait.
    wr(vco_cal_pkg::ADDR_ADC_DIV, 8'h19);
    wr(vco_cal_pkg::ADDR_FINE_HIGH_ADC, 8'h0c);
    repeat (1800) @(negedge i_sys_clk);
    wr(vco_cal_pkg::ADDR_RB_SEL_COARSE, 8'ha2);
    rd(vco_cal_pkg::ADDR_RB_DATA_LOW);
    `CHK(o_reg_rdata, 8'h7d)
    // Gated for two converter periods, so a running clock would show rises.
    wr(vco_cal_pkg::ADDR_ADC_CLK_GATE, 8'h04);
    rises(220);
    `CHK(n, 0)
    wr(vco_cal_pkg::ADDR_FINE_HIGH_ADC, 8'h00);
    stop_test();
  end
endmodule // vco_autocal_tb_top
`default_nettype wire
